// ### rtl/ppc_pkg.sv
package ppc_pkg;

	// =====================================================
	// register map (byte addresses on apb)
	localparam int         ADDR_W     = 8;
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_LOC_A  = 8'h04;
	localparam logic [7:0] OFS_LOC_B  = 8'h08;
	localparam logic [7:0] OFS_SERIAL = 8'h0c;
	localparam logic [7:0] OFS_BUSCFG = 8'h10;
	localparam logic [7:0] OFS_IRQ    = 8'h14;

	// =====================================================
	// control/status fields
	localparam int B_SIF_COPY = 15;
	localparam int B_WIDTH    = 13;
	localparam int B_ODS_ACT  = 12;
	localparam int B_IDS_ACT  = 11;
	localparam int B_SC_MODE  = 10;
	localparam int B_EN       = 5;
	localparam int NFLAGS     = 5;
	localparam int F_SIF      = 4;
	localparam int F_SOE      = 3;
	localparam int F_IS       = 2;
	localparam int F_OS       = 1;
	localparam int F_EXT      = 0;
	localparam int B_CFG_SPLIT = 0;
	localparam int B_CFG_OUT   = 1;
	localparam int B_IRQ_RET   = 0;
	localparam int B_IRQ_TRAP  = 1;

	localparam int          DW        = 16;
	localparam logic [15:0] SPLIT_OE  = 16'h00ff;
	localparam logic [1:0]  VEC_HW    = 2'h1;
	localparam logic [1:0]  VEC_SW    = 2'h2;

	// =====================================================
	// timing: strobe unit is two input-clock high periods
	localparam int CLK_NS       = 40;
	localparam int CKI_HIGH_NS  = 20;
	localparam int STB_T_NS     = 2 * CKI_HIGH_NS;
	localparam int STB_T_CYC    = (STB_T_NS / CLK_NS) < 1 ? 1 : STB_T_NS / CLK_NS;
	localparam int STB_CW       = 4;

	// =====================================================
	// carriers
	typedef struct packed {
		logic [DW-1:0] data;
		logic          ids;
		logic          ods;
		logic          ext_irq;
	} ppc_pin_in_type;

	typedef struct packed {
		logic [DW-1:0] data;
		logic [DW-1:0] data_oe;
		logic          sel;
		logic          ods;
		logic          ods_oe;
		logic          ids;
		logic          ids_oe;
	} ppc_pin_out_type;

	typedef struct packed {
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
		logic [1:0]        width;
		logic              ods_act;
		logic              ids_act;
		logic              sc_mode;
		logic [NFLAGS-1:0] en;
		logic [NFLAGS-1:0] flags;
		logic              cfg_split;
		logic              cfg_out;
		logic [DW-1:0]     in_data;
		ppc_pin_in_type    s1;
		ppc_pin_in_type    s2;
		ppc_pin_in_type    s3;
		ppc_pin_in_type    filt;
		logic [STB_CW-1:0] ods_cnt;
		logic [STB_CW-1:0] ids_cnt;
		ppc_pin_out_type   pout;
		logic              irq_req;
		logic              irq_ack;
		logic              jam;
		logic [1:0]        jam_vec;
	} ppc_state_type;

	localparam ppc_state_type ST_RESET = '0;

endpackage

// ### rtl/ppc_port.sv
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
// Contract
// - sixteen-bit data bus carries words both ways.
// - bus is split 8 in plus 8 out, or full 16 in or out.
// - active mode device drives strobe; passive mode outside drives it.
// - input and output strobe modes chosen independently.
// - width code 0..3 gives strobe length T..4T; T is two clock highs.
// - control bit 12 sets output strobe active when 1.
// - control bit 11 sets input strobe active when 1.
// - low five status bits are read-only; writes leave them.
// - status order: serial full, serial empty, input, output, external.
// - bit 15 reads a copy of the serial-input-full flag.
// - five enable bits gate the five sources, same order.
// - reset clears all five enables.
// - select line low for location a write, high for b.
// - location write sends data out; read returns outside data.
// - in active output mode a strobe accompanies every data write on the port.
// - one external and four internal request conditions.
// - external pin assertion raises the external-request flag.
// - serial input loaded raises serial-input-full.
// - serial output taken raises serial-output-empty.
// - outside write into input register raises input-strobe flag.
// - outside read of output buffer raises output-strobe flag.
// - hardware interrupt jams vector 1, trap jams vector 2.
// - shadow copying of program counter off during service.
// - serial read/write and location read/write clear their flags.
// - acknowledge on recognition masks external pin until return.
// - external flag clears on acknowledge fall; all flags clear on reset.
module ppc_port
	import ppc_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,
	input  wire logic                  ce,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire ppc_pin_in_type        pins_in,
	output ppc_pin_out_type            pins_out,
	input  wire logic                  ser_in_loaded,
	input  wire logic                  ser_out_taken,
	output logic                       irq_req,
	output logic                       irq_ack,
	output logic                       jam,
	output logic      [1:0]            jam_vec,
	output logic                       shadow_off
);

	ppc_state_type     r;
	ppc_state_type     next_r;
	logic              acc;
	logic              done;
	logic              wr;
	logic              rd;
	logic              is_loc;
	logic [NFLAGS-1:0] set;
	logic [NFLAGS-1:0] clr;
	logic [STB_CW-1:0] plen;
	logic              ids_rise;
	logic              ods_rise;
	logic              irq_rise;

	assign is_loc = (paddr == OFS_LOC_A) || (paddr == OFS_LOC_B);

	// =====================================================
	// next state
	always_comb begin
		next_r = r;
		set    = '0;
		clr    = '0;
		acc    = psel && penable;
		done   = acc && r.pready;
		wr     = done && pwrite;
		rd     = done && !pwrite;
		plen   = STB_CW'((32'(r.width) + 32'd1) * STB_T_CYC);

		// pin inputs: a change counts once stages two and three agree
		next_r.s1   = pins_in;
		next_r.s2   = r.s1;
		next_r.s3   = r.s2;
		next_r.filt = ppc_pin_in_type'((r.s2 & r.s3) | ((r.s2 ^ r.s3) & r.filt));
		ids_rise = next_r.filt.ids && !r.filt.ids;
		ods_rise = next_r.filt.ods && !r.filt.ods;
		irq_rise = next_r.filt.ext_irq && !r.filt.ext_irq;

		// =====================================================
		// apb: one wait state, read data captured with pready
		next_r.pready = acc && !r.pready;
		if (acc && !r.pready) begin
			next_r.pslverr = 1'b0;
			next_r.prdata  = '0;
			case (paddr)
				OFS_CTRL: begin
					next_r.prdata[DW-1:0] = {r.flags[F_SIF], r.width, r.ods_act,
						r.ids_act, r.sc_mode, r.en, r.flags};
				end
				OFS_LOC_A, OFS_LOC_B: begin
					next_r.prdata[DW-1:0] = r.in_data;
				end
				OFS_SERIAL: begin
					next_r.prdata = '0;
				end
				OFS_BUSCFG: begin
					next_r.prdata[B_CFG_OUT:B_CFG_SPLIT] = {r.cfg_out, r.cfg_split};
				end
				OFS_IRQ: begin
					next_r.prdata[2:0] = {r.jam_vec, r.irq_ack};
				end
				default: begin
					next_r.pslverr = 1'b1;
				end
			endcase
		end

		// =====================================================
		// strobe pulses; a new location write (output) or read (input) below restarts them
		if (r.ods_cnt != '0) begin
			next_r.ods_cnt = r.ods_cnt - STB_CW'(1);
			if (r.ods_cnt == STB_CW'(1)) begin
				next_r.pout.ods = 1'b0;
				set[F_OS]       = 1'b1;
			end
		end
		if (r.ids_cnt != '0) begin
			next_r.ids_cnt = r.ids_cnt - STB_CW'(1);
			if (r.ids_cnt == STB_CW'(1)) begin
				next_r.pout.ids = 1'b0;
				next_r.in_data  = r.filt.data;
				set[F_IS]       = 1'b1;
			end
		end
		// passive strobes come from the outside party
		if (!r.ids_act && ids_rise) begin
			next_r.in_data = next_r.filt.data;
			set[F_IS]      = 1'b1;
		end
		if (!r.ods_act && ods_rise) begin
			set[F_OS] = 1'b1;
		end
		set[F_SIF] = set[F_SIF] | ser_in_loaded;
		set[F_SOE] = set[F_SOE] | ser_out_taken;
		if (irq_rise && !r.irq_ack) begin
			set[F_EXT] = 1'b1;
		end

		// =====================================================
		// register writes and access side effects
		if (wr) begin
			case (paddr)
				OFS_CTRL: begin
					// status bits are not taken from pwdata
					next_r.width   = pwdata[B_WIDTH+:2];
					next_r.ods_act = pwdata[B_ODS_ACT];
					next_r.ids_act = pwdata[B_IDS_ACT];
					next_r.sc_mode = pwdata[B_SC_MODE];
					next_r.en      = pwdata[B_EN+:NFLAGS];
				end
				OFS_LOC_A, OFS_LOC_B: begin
					next_r.pout.data = pwdata[DW-1:0];
					next_r.pout.sel  = (paddr == OFS_LOC_B);
					clr[F_OS]        = 1'b1;
					if (r.ods_act) begin
						next_r.ods_cnt  = plen;
						next_r.pout.ods = 1'b1;
					end
				end
				OFS_SERIAL: begin
					clr[F_SOE] = 1'b1;
				end
				OFS_BUSCFG: begin
					next_r.cfg_split = pwdata[B_CFG_SPLIT];
					next_r.cfg_out   = pwdata[B_CFG_OUT];
				end
				OFS_IRQ: begin
					if (pwdata[B_IRQ_RET] && r.irq_ack) begin
						next_r.irq_ack = 1'b0;
						clr[F_EXT]     = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		if (rd && is_loc) begin
			clr[F_IS] = 1'b1;
			// active input strobe asks the outside for the next word
			if (r.ids_act) begin
				next_r.ids_cnt  = plen;
				next_r.pout.ids = 1'b1;
			end
		end
		if (rd && paddr == OFS_SERIAL) begin
			clr[F_SIF] = 1'b1;
		end
		next_r.flags = (r.flags & ~clr) | set; // set beats clear

		// =====================================================
		// pin drive
		next_r.pout.ods_oe  = next_r.ods_act;
		next_r.pout.ids_oe  = next_r.ids_act;
		next_r.pout.data_oe = next_r.cfg_split ? SPLIT_OE : {DW{next_r.cfg_out}};

		// =====================================================
		// interrupt recognition
		// from next flags: a stale request after a clear would re-acknowledge at once
		next_r.irq_req = |(next_r.flags & next_r.en);
		next_r.jam     = 1'b0;
		if (wr && paddr == OFS_IRQ && pwdata[B_IRQ_TRAP] && !r.irq_ack) begin
			next_r.irq_ack = 1'b1;
			next_r.jam     = 1'b1;
			next_r.jam_vec = VEC_SW;
		end else if (r.irq_req && !r.irq_ack) begin
			next_r.irq_ack = 1'b1;
			next_r.jam     = 1'b1;
			next_r.jam_vec = VEC_HW;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			r <= ST_RESET;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign prdata     = r.prdata;
	assign pready     = r.pready;
	assign pslverr    = r.pslverr;
	assign pins_out   = r.pout;
	assign irq_req    = r.irq_req;
	assign irq_ack    = r.irq_ack;
	assign jam        = r.jam;
	assign jam_vec    = r.jam_vec;
	assign shadow_off = r.irq_ack;

	// =====================================================
	// checks (written for ce held high)
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	AST_EN_RESET: assert property ($past(sys_rst) |-> r.en == '0 && r.flags == '0)
		else $error("enables or flags not clear after reset");
	AST_SEL_LOC: assert property (ce && wr && is_loc |=>
		r.pout.sel == ($past(paddr) == OFS_LOC_B))
		else $error("select line does not follow location");
	AST_ODS_PULSE: assert property (ce && wr && is_loc && r.ods_act && r.width == 2'h1
		|=> r.pout.ods [*2] ##1 !r.pout.ods)
		else $error("output strobe width wrong for code 01");
	AST_RO_STATUS: assert property (ce && wr && paddr == OFS_CTRL |=>
		(r.flags & $past(r.flags)) == $past(r.flags))
		else $error("control write changed status flags");
	AST_BIT15: assert property (r.pready && paddr == OFS_CTRL |->
		r.prdata[15] == r.prdata[F_SIF])
		else $error("bit 15 differs from serial full flag");
	AST_IS_LATCH: assert property (ce && !r.ids_act && ids_rise |=>
		r.flags[F_IS] && r.in_data == $past(next_r.filt.data))
		else $error("passive input strobe did not latch data");
	AST_OS_SET: assert property (ce && !r.ods_act && ods_rise |=> r.flags[F_OS])
		else $error("passive output strobe did not set flag");
	AST_LOC_CLR: assert property (ce && rd && is_loc && !set[F_IS] |=> !r.flags[F_IS])
		else $error("location read did not clear input flag");
	AST_REQ: assert property (ce && (|(set & r.en)) && !(wr && paddr == OFS_CTRL) |=>
		r.irq_req)
		else $error("enabled flag raised no request");
	AST_ACK: assert property (ce && r.irq_req && !r.irq_ack && !wr |=>
		r.irq_ack && r.jam && r.jam_vec == VEC_HW)
		else $error("request not acknowledged with vector 1");
	AST_MASK: assert property (ce && r.irq_ack && r.flags[F_EXT] == 1'b0 && !wr |=>
		!r.flags[F_EXT])
		else $error("external flag set while acknowledged");
	AST_EXT_CLR: assert property ($fell(r.irq_ack) |-> !r.flags[F_EXT])
		else $error("external flag survived acknowledge fall");
	AST_IDS_PULSE: assert property (ce && rd && is_loc && r.ids_act && r.width == 2'h2
		|=> r.pout.ids [*3] ##1 (!r.pout.ids || $past(rd)))
		else $error("input strobe width wrong for code 10");
	AST_CFG_OE: assert property (ce && wr && paddr == OFS_CTRL |=>
		r.pout.ods_oe == $past(pwdata[B_ODS_ACT]) && r.pout.ids_oe == $past(pwdata[B_IDS_ACT]))
		else $error("strobe direction does not follow control write");
	AST_EN_WR: assert property (ce && wr && paddr == OFS_CTRL |=>
		r.en == $past(pwdata[B_EN+:NFLAGS]))
		else $error("enable bits do not follow control write");
	AST_DATA_OUT: assert property (ce && wr && is_loc |=>
		r.pout.data == $past(pwdata[DW-1:0]))
		else $error("location write did not reach the port");
	AST_SPLIT_OE: assert property (ce && wr && paddr == OFS_BUSCFG && pwdata[B_CFG_SPLIT] |=>
		r.pout.data_oe == SPLIT_OE)
		else $error("split mode drive mask wrong");
	AST_SIF_SET: assert property (ce && ser_in_loaded |=> r.flags[F_SIF])
		else $error("serial input load did not set its flag");
	AST_SOE_SET: assert property (ce && ser_out_taken |=> r.flags[F_SOE])
		else $error("serial output take did not set its flag");
	AST_EXT_SET: assert property (ce && irq_rise && !r.irq_ack |=> r.flags[F_EXT])
		else $error("external request did not set its flag");
	AST_TRAP: assert property (ce && wr && paddr == OFS_IRQ && pwdata[B_IRQ_TRAP] &&
		!r.irq_ack |=> r.irq_ack && r.jam && r.jam_vec == VEC_SW)
		else $error("trap not acknowledged with vector 2");
	AST_JAM_ONCE: assert property (ce && r.jam |=> !r.jam)
		else $error("jam pulse longer than one cycle");

	COV_ODS: cover property (wr && is_loc && r.ods_act);
	COV_IDS: cover property (!r.ids_act && ids_rise);
	COV_HW_IRQ: cover property ($rose(r.irq_ack) && r.jam_vec == VEC_HW);
	COV_TRAP: cover property ($rose(r.irq_ack) && r.jam_vec == VEC_SW);
	COV_SPLIT: cover property (r.cfg_split && r.pout.data_oe == SPLIT_OE);

endmodule

// ### verif/ppc_ext.sv
`timescale 1ns/1ps
module ppc_ext
	import ppc_pkg::*;
(
	input  wire logic     mclk,
	output ppc_pin_in_type drv
);
	initial drv = '0;

	// ====================================
	// outside writer: word held around the strobe, then scrambled
	task automatic send(input logic [15:0] w);
		@(posedge mclk);
		drv.data <= w;
		repeat (2) @(posedge mclk);
		drv.ids <= 1'b1;
		repeat (4) @(posedge mclk);
		drv.ids <= 1'b0;
		repeat (4) @(posedge mclk);
		drv.data <= ~w;
	endtask

	// outside reader of the output buffer
	task automatic take;
		@(posedge mclk);
		drv.ods <= 1'b1;
		repeat (4) @(posedge mclk);
		drv.ods <= 1'b0;
	endtask

	// held well past the minimum so the filter never drops it
	task automatic request;
		@(posedge mclk);
		drv.ext_irq <= 1'b1;
		repeat (6) @(posedge mclk);
		drv.ext_irq <= 1'b0;
	endtask
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
	import ppc_pkg::*;
	logic            mclk = 1'b0;
	logic            sys_rst = 1'b1;
	logic            psel = 1'b0;
	logic            penable = 1'b0;
	logic            pwrite = 1'b0;
	logic [7:0]      paddr = 8'h00;
	logic [31:0]     pwdata = 32'h0;
	logic            sil = 1'b0;
	logic            sot = 1'b0;
	logic [31:0]     prdata, rdv;
	logic            pready, pslverr, perr, irq_req, irq_ack, jam, shadow_off;
	logic [1:0]      jam_vec;
	ppc_pin_in_type  pins_in, xd;
	ppc_pin_out_type po;
	int              n_errors = 0;
	int              n_tests = 0;

	always #20 mclk = ~mclk;

	// wire level: device wins where it drives
	assign pins_in = {(po.data & po.data_oe) | (xd.data & ~po.data_oe),
		po.ids_oe ? po.ids : xd.ids, po.ods_oe ? po.ods : xd.ods, xd.ext_irq};

	ppc_port u_dut (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pins_in(pins_in), .pins_out(po),
		.ser_in_loaded(sil), .ser_out_taken(sot), .irq_req(irq_req), .irq_ack(irq_ack),
		.jam(jam), .jam_vec(jam_vec), .shadow_off(shadow_off));
	ppc_ext ext (.mclk(mclk), .drv(xd));

	// ====================================
	// tasks
	task automatic close_out;
		if (n_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk($sformatf("reg %h", a), e, rdv);
	endtask

	// counts high cycles of a device strobe
	task automatic plen(input logic ids, output int n);
		n = 0;
		repeat (12) begin
			@(posedge mclk);
			if ((ids ? po.ids : po.ods) === 1'b1)
				n++;
		end
	endtask

	// ====================================
	// tests
	initial begin
		int n;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		rchk(OFS_CTRL, 32'h0);
		apb(8'h18, 1'b0, 32'h0);
		chk("unmapped", 32'h1, {31'h0, perr});
		apb(OFS_CTRL, 1'b1, 32'hffff);
		rchk(OFS_CTRL, 32'h7fe0);
		for (int w = 0; w < 4; w++) begin
			apb(OFS_CTRL, 1'b1, 32'(w << 13) | 32'h1000);
			apb(OFS_LOC_A, 1'b1, 32'h1234 + w);
			plen(1'b0, n);
			chk("ods len", 32'(w + 1), 32'(n));
			chk("data", 32'h1234 + w, {16'h0, po.data});
			chk("sel", 32'h0, {31'h0, po.sel});
			rchk(OFS_CTRL, 32'(w << 13) | 32'h1002);
		end
		apb(OFS_CTRL, 1'b1, 32'h0);
		apb(OFS_LOC_B, 1'b1, 32'hbeef);
		@(negedge mclk);
		chk("sel oe", 32'h2, {30'h0, po.sel, po.ods_oe});
		rchk(OFS_CTRL, 32'h0);
		ext.take();
		rchk(OFS_CTRL, 32'h2);
		for (int c = 2; c >= 0; c--) begin
			apb(OFS_BUSCFG, 1'b1, 32'(c));
			@(negedge mclk);
			chk("oe", c == 2 ? 32'hffff : c == 1 ? 32'h00ff : 32'h0, {16'h0, po.data_oe});
		end
		ext.send(16'ha55a);
		rchk(OFS_CTRL, 32'h6);
		rchk(OFS_LOC_A, 32'ha55a);
		rchk(OFS_CTRL, 32'h2);
		apb(OFS_CTRL, 1'b1, 32'h4800);
		@(negedge mclk);
		chk("strobe oe", 32'h2, {30'h0, po.ids_oe, po.ods_oe});
		rchk(OFS_LOC_B, 32'ha55a);
		plen(1'b1, n);
		chk("ids len", 32'h3, 32'(n));
		rchk(OFS_CTRL, 32'h4806);
		rchk(OFS_LOC_A, 32'h5aa5);
		repeat (8) @(posedge mclk);
		sil <= 1'b1;
		sot <= 1'b1;
		@(posedge mclk);
		sil <= 1'b0;
		sot <= 1'b0;
		apb(OFS_CTRL, 1'b1, 32'h0);
		rchk(OFS_CTRL, 32'h801e);
		chk("req off", 32'h0, {31'h0, irq_req});
		apb(OFS_CTRL, 1'b1, 32'h0200);
		repeat (4) @(negedge mclk);
		chk("irq", 32'h1d, {27'h0, irq_req, irq_ack, shadow_off, jam_vec});
		rchk(OFS_SERIAL, 32'h0);
		apb(OFS_IRQ, 1'b1, 32'h1);
		@(negedge mclk);
		chk("irq", 32'h0, {30'h0, irq_req, irq_ack});
		rchk(OFS_CTRL, 32'h020e);
		apb(OFS_SERIAL, 1'b1, 32'h0);
		apb(OFS_CTRL, 1'b1, 32'h0020);
		ext.request();
		repeat (4) @(negedge mclk);
		chk("irq", 32'h1d, {27'h0, irq_req, irq_ack, shadow_off, jam_vec});
		rchk(OFS_CTRL, 32'h0027);
		apb(OFS_IRQ, 1'b1, 32'h1);
		rchk(OFS_CTRL, 32'h0026);
		apb(OFS_IRQ, 1'b1, 32'h2);
		@(negedge mclk);
		chk("jam", 32'h1, {31'h0, jam});
		@(negedge mclk);
		chk("jam end", 32'h0, {31'h0, jam});
		rchk(OFS_IRQ, 32'h5);
		chk("shadow", 32'h1, {31'h0, shadow_off});
		apb(OFS_IRQ, 1'b1, 32'h1);
		rchk(OFS_IRQ, 32'h4);
		close_out;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		close_out;
	end
endmodule
